/* rtl/sdlc_frame_status_fifo.sv */
// Frame status queue of an SDLC receiver with its pointer-addressed register port.
`timescale 1ns/1ps
`include "sfifo_defs.svh"

module sdlc_frame_status_fifo
    import sfifo_pkg::*;
#(
    parameter int DEPTH = `STATUS_DEPTH
) (
    // Clock and reset.
    input  wire logic       CLK,
    input  wire logic       RSTN,
    // Parallel register bus.
    input  wire logic       BUS_RD,
    input  wire logic       BUS_WR,
    input  wire logic       BUS_DC,
    input  wire logic [7:0] BUS_DIN,
    output logic      [7:0] BUS_DOUT,
    output logic            BUS_DOE_N,
    // Receiver datapath.
    input  wire logic       SDLC_MODE,
    input  wire logic       RX_CHAR,
    input  wire logic       RX_FRAME_END,
    input  wire logic       RX_ABORT,
    input  wire logic [2:0] RX_RESIDUE,
    input  wire logic       RX_OVERRUN,
    input  wire logic       RX_CRC_ERR,
    input  wire logic       RX_ALL_SENT,
    input  wire logic       RX_PARITY,
    input  wire logic       RX_EOF_LIVE,
    input  wire logic [7:0] MAIN_STATUS,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_TOP_EOF,
    input  wire logic       RX_TOP_ERR,
    // Receiver control and interrupt requests.
    output logic            RX_DATA_POP,
    output logic            CRC_RESET,
    output logic            RX_LOCK,
    output logic            RX_DATA_INT,
    output logic            SPECIAL_INT,
    output logic            IUS_RESET
);

    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    // Whole state of the block.
    typedef struct packed {
        entry_t [DEPTH-1:0]  mem;       // Queue storage.
        logic [PW-1:0]       wp;        // Write index.
        logic [PW-1:0]       rp;        // Read index.
        logic [LW-1:0]       level;     // Entries held.
        logic                ovf;       // Sticky overflow flag.
        logic                armed;     // Upper count read seen with data available.
        logic [3:0]          ptr;       // Register pointer.
        logic [7:0]          int_mode;  // Interrupt mode control.
        logic [7:0]          ext_ctrl;  // Extended feature control.
        logic [13:0]         bcount;    // Running byte count.
        logic [7:0]          dout;      // Read data.
        logic                doe_n;     // Read data drive enable, low drives.
        logic                pop;       // Receive data FIFO pop pulse.
        logic                crc_rst;   // CRC checker reset pulse.
        logic                lock;      // Receive data FIFO locked.
        logic                dint;      // Receive data interrupt pulse.
        logic                sint;      // Special condition interrupt level.
        logic                interrupt_under_service;       // Reset highest under-service pulse.
        logic                top_eof;   // Previous top-of-FIFO EOF marker.
    } state_t;

    state_t s_q;                        // Registered state.
    state_t s_d;                        // Next state.

    logic        en;                    // Queue active.
    logic        nonempty;              // Queue holds data.
    logic        full;                  // Queue holds DEPTH entries.
    logic        push;                  // Frame end or abort this cycle.
    logic        special_only;          // Special-condition-only receive interrupts.
    logic [3:0]  idx;                   // Register addressed this access.
    logic [3:0]  eff;                   // Register after mirroring.
    entry_t      head;                  // Oldest queued entry.

    // Wraps a queue index after the last entry.
    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    assign en           = s_q.ext_ctrl[`EXT_QEN_BIT] & SDLC_MODE;
    assign nonempty     = (s_q.level != '0);
    assign full         = (s_q.level == LW'(DEPTH));
    assign push         = RX_FRAME_END | RX_ABORT;
    assign special_only = s_q.int_mode[`MODE_D4_BIT] & s_q.int_mode[`MODE_D3_BIT];
    assign head         = s_q.mem[s_q.rp];
    assign idx          = BUS_DC ? `REG_DATA : s_q.ptr;
    assign eff          = (!en && idx[3:2] == 2'h1) ? {2'h0, idx[1:0]} : idx;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next state.

    // Computes all register updates for one clock.
    always_comb begin
        logic [7:0] live_st;
        logic [7:0] head_st;
        logic [7:0] rv;
        logic       from_q;
        logic       pop_q;
        logic       push_ok;
        live_st = {RX_EOF_LIVE, RX_CRC_ERR, RX_OVERRUN, RX_PARITY, RX_RESIDUE, RX_ALL_SENT};
        // only residue, overrun and CRC come from the entry
        head_st = {RX_EOF_LIVE, head.crc_err, head.overrun, RX_PARITY, head.residue,
                   RX_ALL_SENT};
        from_q  = en & nonempty;
        pop_q   = 1'b0;
        push_ok = 1'b0;
        rv      = 8'h00;
        s_d         = s_q;
        s_d.pop     = 1'b0;
        s_d.crc_rst = 1'b0;
        s_d.dint    = 1'b0;
        s_d.interrupt_under_service     = 1'b0;
        s_d.doe_n   = 1'b1;
        // Read value selection.
        unique case (eff)
            `REG_MAIN: begin
                rv = MAIN_STATUS;
            end
            // head entry while queued; live when empty
            `REG_RXST: begin
                rv = from_q ? head_st : live_st;
            end
            `REG_CNT_LO: begin
                rv = from_q ? head.count[7:0] : s_q.bcount[7:0];
            end
            // availability in D6; upper bits and flags
            `REG_CNT_HI: begin
                rv = {s_q.ovf, nonempty, from_q ? head.count[13:8] : s_q.bcount[13:8]};
            end
            `REG_DATA: begin
                rv = RX_DATA;
            end
            `REG_EXT: begin
                rv = {s_q.ext_ctrl[7:3], en, s_q.ext_ctrl[1:0]};
            end
            default: begin
                rv = 8'h00;
            end
        endcase
        // Read access.
        if (BUS_RD) begin
            s_d.dout  = rv;
            s_d.doe_n = 1'b0;
            // pointer clears after a control access
            if (!BUS_DC) begin
                s_d.ptr = 4'h0;
            end
            if (eff == `REG_CNT_HI && en) begin
                // latch availability for the status read
                s_d.armed = nonempty;
            end else if (eff == `REG_RXST && en) begin
                // one pop per upper count read; never when empty
                pop_q     = s_q.armed & from_q;
                s_d.armed = 1'b0;
            end else if (eff == `REG_DATA && !s_q.lock) begin
                s_d.pop = 1'b1;
                // errored character locks the data FIFO
                if (RX_TOP_ERR) begin
                    s_d.lock = 1'b1;
                    s_d.sint = 1'b1;
                // EOF only locks when anti-lock is off
                end else if (RX_TOP_EOF && special_only && !en) begin
                    s_d.lock = 1'b1;
                    s_d.sint = 1'b1;
                end
            end
        end
        // Write access.
        if (BUS_WR && !BUS_DC) begin
            if (s_q.ptr == 4'h0) begin
                s_d.ptr = {BUS_DIN[5:3] == CMD_POINT_HIGH, BUS_DIN[2:0]};
                if (BUS_DIN[5:3] == CMD_ERR_RESET) begin
                    s_d.lock = 1'b0;
                    s_d.sint = 1'b0;
                end
                s_d.interrupt_under_service = (BUS_DIN[5:3] == CMD_IUS_RESET);
            end else begin
                if (s_q.ptr == 4'h1) begin
                    s_d.int_mode = BUS_DIN;
                end else if (s_q.ptr == `REG_EXT) begin
                    s_d.ext_ctrl = BUS_DIN;
                end
                // pointer clears after the pointed write
                s_d.ptr = 4'h0;
            end
        end
        // anti-lock raises data interrupt on EOF reaching top
        s_d.top_eof = RX_TOP_EOF;
        if (en && special_only && RX_TOP_EOF && !s_q.top_eof) begin
            s_d.dint = 1'b1;
        end
        // frame end; abort; CRC reset and count restart
        if (push) begin
            s_d.bcount  = 14'h0000;
            s_d.crc_rst = 1'b1;
        end else if (RX_CHAR) begin
            s_d.bcount = s_q.bcount + 14'h0001;
        end
        if (push && en) begin
            // a frame end or abort into a full queue overflows unless an entry pops that cycle
            if (full && !pop_q) begin
                s_d.ovf = 1'b1;
            end else begin
                push_ok = 1'b1;
                s_d.mem[s_q.wp] = '{residue: RX_RESIDUE, overrun: RX_OVERRUN,
                                    crc_err: RX_CRC_ERR, count: s_q.bcount};
                s_d.wp = wrap_inc(s_q.wp);
            end
        end
        if (pop_q) begin
            s_d.rp = wrap_inc(s_q.rp);
        end
        s_d.level = s_q.level + LW'(push_ok) - LW'(pop_q);
        // pointers held clear while disabled; overflow clears on disable
        if (!en) begin
            s_d.wp    = '0;
            s_d.rp    = '0;
            s_d.level = '0;
            s_d.ovf   = 1'b0;
            s_d.armed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // State register.

    // reset clears the enable bit and all control state.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q          <= '0;
            s_q.doe_n    <= 1'b1;
            s_q.ext_ctrl <= `EXT_CTRL_RST;
            s_q.int_mode <= `INT_MODE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign BUS_DOUT    = s_q.dout;
    assign BUS_DOE_N   = s_q.doe_n;
    assign RX_DATA_POP = s_q.pop;
    assign CRC_RESET   = s_q.crc_rst;
    assign RX_LOCK     = s_q.lock;
    assign RX_DATA_INT = s_q.dint;
    assign SPECIAL_INT = s_q.sint;
    assign IUS_RESET   = s_q.interrupt_under_service;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    status_guard_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (BUS_RD && !BUS_DC && s_q.ptr == `REG_RXST && !s_q.armed && en) |=> $stable(s_q.rp))
        else $error("status read without armed flag popped an entry");

    enable_readback_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (BUS_RD && !BUS_DC && s_q.ptr == `REG_EXT) |=> (BUS_DOUT[2] == $past(en)))
        else $error("enable readback wrong");

    avail_flag_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (BUS_RD && !BUS_DC && s_q.ptr == `REG_CNT_HI && en)
        |=> (BUS_DOUT[6] == ($past(s_q.level) != '0)))
        else $error("availability flag wrong");

    overflow_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (en && full && push && !BUS_RD) |=> s_q.ovf)
        else $error("overflow not flagged");

    overflow_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.ovf && en) |=> s_q.ovf)
        else $error("overflow flag cleared while enabled");

    queue_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
        !en |=> (s_q.level == '0 && s_q.wp == '0))
        else $error("queue not cleared while disabled");

    pointer_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
        ((BUS_RD || BUS_WR) && !BUS_DC && s_q.ptr != 4'h0) |=> (s_q.ptr == 4'h0))
        else $error("pointer not cleared");

    crc_restart_a: assert property (@(posedge CLK) disable iff (!RSTN)
        push |=> (CRC_RESET && s_q.bcount == 14'h0000))
        else $error("no CRC reset or counter restart at frame end");

    no_underflow_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (en && s_q.level == '0) |=> $stable(s_q.rp))
        else $error("empty queue popped");

    lock_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.lock && !(BUS_WR && !BUS_DC && s_q.ptr == 4'h0)) |=> (RX_LOCK && !RX_DATA_POP))
        else $error("lock released without error reset");

endmodule

/* rtl/sfifo_defs.svh */
// Register indices, field positions, reset values and queue geometry of the status queue.
`ifndef SFIFO_DEFS_SVH
`define SFIFO_DEFS_SVH

// Register indices reached through the pointer.
`define REG_MAIN       4'h0
`define REG_RXST       4'h1
`define REG_CNT_LO     4'h6
`define REG_CNT_HI     4'h7
`define REG_DATA       4'h8
`define REG_EXT        4'hF

// Field positions.
`define EXT_QEN_BIT    2
`define MODE_D3_BIT    3
`define MODE_D4_BIT    4
`define HI_AVAIL_BIT   6
`define HI_OVF_BIT     7

// Reset values of the writable registers.
`define EXT_CTRL_RST   8'h00
`define INT_MODE_RST   8'h00

// Queue geometry.
`define STATUS_DEPTH   10
`define COUNT_W        14

`endif

/* rtl/sfifo_pkg.sv */
// Types shared by the frame status queue.
package sfifo_pkg;

    // One queued frame: residue, overrun, CRC error and byte count.
    typedef struct packed {
        logic [2:0]          residue;
        logic                overrun;
        logic                crc_err;
        logic [13:0]         count;
    } entry_t;

    // Command field held in bits D5..D3 of the command pointer register.
    typedef enum logic [2:0] {
        CMD_NULL       = 3'h0,
        CMD_POINT_HIGH = 3'h1,
        CMD_ERR_RESET  = 3'h6,
        CMD_IUS_RESET  = 3'h7
    } cmd_t;

endpackage

/* sim/host_bus_model.sv */
// Host model that masters the pointer-addressed register bus.
`timescale 1ns/1ps
module host_bus_model (
    // Clock.
    input  wire logic       CLK,
    // Register bus.
    output logic            BUS_RD,
    output logic            BUS_WR,
    output logic            BUS_DC,
    output logic      [7:0] BUS_DIN,
    input  wire logic [7:0] BUS_DOUT,
    input  wire logic       BUS_DOE_N
);
    // The bus idles with no strobe.
    initial begin
        BUS_RD = 1'b0;
        BUS_WR = 1'b0;
        BUS_DC = 1'b0;
        BUS_DIN = 8'hA5;
    end

    // One write; data is inverted once released so it is never seen stale.
    task automatic wr(input logic dc, input logic [7:0] d);
        @(posedge CLK);
        #1;
        BUS_WR = 1'b1;
        BUS_DC = dc;
        BUS_DIN = d;
        @(posedge CLK);
        #1;
        BUS_WR = 1'b0;
        BUS_DIN = ~d;
    endtask

    // One read; data and drive window are taken the cycle after the strobe.
    task automatic rd(input logic dc, output logic [7:0] d, output logic oe_n);
        @(posedge CLK);
        #1;
        BUS_RD = 1'b1;
        BUS_DC = dc;
        @(posedge CLK);
        #1;
        d = BUS_DOUT;
        oe_n = BUS_DOE_N;
        BUS_RD = 1'b0;
    endtask

    task automatic prd(input logic [7:0] p, output logic [7:0] d, output logic oe_n);
        wr(1'b0, p);
        rd(1'b0, d, oe_n);
    endtask

    task automatic pwr(input logic [7:0] p, input logic [7:0] v);
        wr(1'b0, p);
        wr(1'b0, v);
    endtask

    task automatic ius_done();
        wr(1'b0, 8'h38);
    endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the frame status queue.
`timescale 1ns/1ps
`include "sfifo_defs.svh"
module testbench
    import sfifo_pkg::*;
;
    logic        CLK, RSTN, BUS_RD, BUS_WR, BUS_DC, BUS_DOE_N, SDLC_MODE, RX_CHAR;
    logic        RX_FRAME_END, RX_ABORT, RX_OVERRUN, RX_CRC_ERR, RX_ALL_SENT, RX_PARITY;
    logic        RX_EOF_LIVE, RX_TOP_EOF, RX_TOP_ERR, RX_DATA_POP, CRC_RESET, RX_LOCK;
    logic        RX_DATA_INT, SPECIAL_INT, IUS_RESET, oe, ov;
    logic [2:0]  RX_RESIDUE;
    logic [7:0]  BUS_DIN, BUS_DOUT, MAIN_STATUS, RX_DATA, d;
    logic [15:0] lf;
    logic [13:0] qc[$];
    logic [4:0]  qs[$];
    int          miscompares, n_tests, pops, p0, i;

    sdlc_frame_status_fifo #(.DEPTH(`STATUS_DEPTH)) sdlc_frame_status_fifo_inst (
        .CLK(CLK), .RSTN(RSTN), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR), .BUS_DC(BUS_DC),
        .BUS_DIN(BUS_DIN), .BUS_DOUT(BUS_DOUT), .BUS_DOE_N(BUS_DOE_N),
        .SDLC_MODE(SDLC_MODE), .RX_CHAR(RX_CHAR), .RX_FRAME_END(RX_FRAME_END),
        .RX_ABORT(RX_ABORT), .RX_RESIDUE(RX_RESIDUE), .RX_OVERRUN(RX_OVERRUN),
        .RX_CRC_ERR(RX_CRC_ERR), .RX_ALL_SENT(RX_ALL_SENT), .RX_PARITY(RX_PARITY),
        .RX_EOF_LIVE(RX_EOF_LIVE), .MAIN_STATUS(MAIN_STATUS), .RX_DATA(RX_DATA),
        .RX_TOP_EOF(RX_TOP_EOF), .RX_TOP_ERR(RX_TOP_ERR), .RX_DATA_POP(RX_DATA_POP),
        .CRC_RESET(CRC_RESET), .RX_LOCK(RX_LOCK), .RX_DATA_INT(RX_DATA_INT),
        .SPECIAL_INT(SPECIAL_INT), .IUS_RESET(IUS_RESET));
    host_bus_model host_bus_model_inst (.CLK(CLK), .BUS_RD(BUS_RD), .BUS_WR(BUS_WR),
        .BUS_DC(BUS_DC), .BUS_DIN(BUS_DIN), .BUS_DOUT(BUS_DOUT), .BUS_DOE_N(BUS_DOE_N));

    // Clock of 20 ns period.
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // Counts accepted data reads.
    always @(posedge CLK) begin
        if (RX_DATA_POP === 1'b1) begin
            pops <= pops + 1;
        end
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        results();
    end

    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Status byte: queued residue, overrun, CRC with the live bits around them.
    function automatic logic [7:0] stat(input logic [4:0] s);
        return {RX_EOF_LIVE, s[0], s[1], RX_PARITY, s[4:2], RX_ALL_SENT};
    endfunction
    function automatic logic [7:0] hi(input logic [13:0] c, input logic a, input logic o);
        return {o, a, c[13:8]};
    endfunction

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Pointed read with its drive window checked.
    task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
        host_bus_model_inst.prd(p, d, oe);
        chk1(oe, 1'b0);
        chk8(d, e);
    endtask

    // Frame of n bytes closed by a flag or an abort; the model keeps ten.
    task automatic frame(input int n, input logic ab);
        lf = nxt(lf);
        @(posedge CLK);
        #1;
        RX_CHAR = 1'b1;
        repeat (n) @(posedge CLK);
        #1;
        RX_CHAR = 1'b0;
        {RX_RESIDUE, RX_OVERRUN, RX_CRC_ERR} = lf[4:0];
        RX_FRAME_END = !ab;
        RX_ABORT = ab;
        @(posedge CLK);
        #1;
        RX_FRAME_END = 1'b0;
        RX_ABORT = 1'b0;
        chk1(CRC_RESET, 1'b1);
        if (qc.size() < `STATUS_DEPTH) begin
            qc.push_back(n[13:0]);
            qs.push_back(lf[4:0]);
        end
    endtask

    task automatic drain();
        while (qc.size() > 0) begin
            rdchk(8'h07, hi(qc[0], 1'b1, ov));
            rdchk(8'h06, qc[0][7:0]);
            rdchk(8'h01, stat(qs[0]));
            void'(qc.pop_front());
            void'(qs.pop_front());
        end
    endtask

    initial begin
        {RSTN, SDLC_MODE, RX_CHAR, RX_FRAME_END, RX_ABORT, RX_RESIDUE} = '0;
        {RX_OVERRUN, RX_CRC_ERR, RX_PARITY, RX_TOP_EOF, RX_TOP_ERR, ov} = '0;
        {RX_EOF_LIVE, RX_ALL_SENT, MAIN_STATUS, RX_DATA, lf} = {2'b11, 32'h3C5A4A36};
        repeat (4) @(posedge CLK);
        #1;
        RSTN = 1'b1;
        chk1(BUS_DOE_N, 1'b1);
        rdchk(8'h0F, 8'h00);
        rdchk(8'h04, MAIN_STATUS);
        rdchk(8'h05, stat(5'h00));
        rdchk(8'h06, 8'h00);
        host_bus_model_inst.pwr(8'h0F, 8'h04);
        rdchk(8'h0F, 8'h00);
        SDLC_MODE = 1'b1;
        rdchk(8'h0F, 8'h04);
        tend("enable");
        lf = nxt(lf);
        {MAIN_STATUS, RX_DATA} = lf;
        p0 = pops;
        host_bus_model_inst.rd(1'b1, d, oe);
        chk8(d, RX_DATA);
        host_bus_model_inst.rd(1'b0, d, oe);
        chk8(d, MAIN_STATUS);
        chk8(8'(pops - p0), 8'h01);
        tend("direct");
        for (i = 0; i < 3; i++) begin
            lf = nxt(lf);
            frame(int'(lf[12:8]) + 1, 1'b0);
        end
        frame(300, 1'b0);
        frame(5, 1'b1);
        RX_PARITY = 1'b1;
        drain();
        rdchk(8'h07, 8'h00);
        rdchk(8'h01, stat({RX_RESIDUE, RX_OVERRUN, RX_CRC_ERR}));
        frame(2, 1'b0);
        frame(3, 1'b0);
        rdchk(8'h07, hi(14'h0002, 1'b1, 1'b0));
        rdchk(8'h01, stat(qs[0]));
        rdchk(8'h01, stat(qs[1]));
        rdchk(8'h07, hi(14'h0003, 1'b1, 1'b0));
        void'(qc.pop_front());
        void'(qs.pop_front());
        drain();
        tend("frames");
        for (i = 0; i < `STATUS_DEPTH; i++) begin
            frame(i + 1, 1'b0);
        end
        rdchk(8'h07, hi(14'h0001, 1'b1, 1'b0));
        frame(40, 1'b0);
        ov = 1'b1;
        drain();
        rdchk(8'h07, 8'h80);
        host_bus_model_inst.pwr(8'h0F, 8'h00);
        host_bus_model_inst.pwr(8'h0F, 8'h04);
        rdchk(8'h07, 8'h00);
        tend("overflow");
        host_bus_model_inst.pwr(8'h01, 8'h18);
        RX_TOP_EOF = 1'b1;
        i = 0;
        while (RX_DATA_INT !== 1'b1 && i < 4) begin
            @(posedge CLK);
            #1;
            i++;
        end
        chk1(i < 4, 1'b1);
        if (i == 4) begin
            results();
        end
        p0 = pops;
        host_bus_model_inst.rd(1'b1, d, oe);
        repeat (2) @(posedge CLK);
        #1;
        chk1(RX_LOCK, 1'b0);
        RX_TOP_EOF = 1'b0;
        RX_TOP_ERR = 1'b1;
        host_bus_model_inst.rd(1'b1, d, oe);
        repeat (2) @(posedge CLK);
        #1;
        chk1(SPECIAL_INT, 1'b1);
        chk1(RX_LOCK, 1'b1);
        host_bus_model_inst.rd(1'b1, d, oe);
        chk8(8'(pops - p0), 8'h02);
        RX_TOP_ERR = 1'b0;
        host_bus_model_inst.wr(1'b0, {2'b00, CMD_ERR_RESET, 3'h0});
        repeat (2) @(posedge CLK);
        #1;
        chk1(RX_LOCK | SPECIAL_INT, 1'b0);
        host_bus_model_inst.ius_done();
        chk1(IUS_RESET, 1'b1);
        host_bus_model_inst.pwr(8'h0F, 8'h00);
        RX_TOP_EOF = 1'b1;
        host_bus_model_inst.rd(1'b1, d, oe);
        chk1(RX_LOCK & SPECIAL_INT, 1'b1);
        RX_TOP_EOF = 1'b0;
        host_bus_model_inst.wr(1'b0, {2'b00, CMD_ERR_RESET, 3'h0});
        chk1(RX_LOCK, 1'b0);
        tend("interrupts");
        results();
    end
endmodule
